// File: src/mloc_pkg.sv
/*
  Shared constants and types for the modem link option command block:
  command codes, reset values, second-output functions, timing and the
  connect message text.
  Assumes a single 25 MHz clock domain for every user of the package.
*/
package mloc_pkg;

  // Binary command codes, used as the register address
  localparam logic [7:0] CMD_CONNECT_REPORT = 8'h38;
  localparam logic [7:0] CMD_LEAVE_MODE = 8'h09;
  localparam logic [7:0] CMD_OUT_C_TIMEOUT = 8'h2e;
  localparam logic [7:0] CMD_OUT_B_FUNC = 8'h1f;

  // Reset values and limits
  localparam logic CONNECT_REPORT_RST = 1'b0;
  localparam logic [15:0] CONNECT_REPORT_MAX = 16'h0001;
  localparam logic [15:0] OUT_C_TIMEOUT_RST = 16'h0003;
  localparam logic [15:0] OUT_B_FUNC_MAX = 16'h0004;

  // Number of bytes a read returns
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // Timing: one timeout unit is a second
  localparam int SECOND_NS = 1_000_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

  // Connect message: a word followed by four hex digits
  localparam logic [55:0] MSG_WORD = "CONNECT";
  localparam logic [3:0] MSG_WORD_LEN = 4'h7;
  localparam logic [3:0] MSG_LAST_IDX = 4'ha;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_ALPHA_OFS = 8'h37;

  // Second output line functions, in the order of their codes 0 to 4
  typedef enum logic [2:0] {
    B_CTS,
    B_TXEN_LOW,
    B_PASS_HIGH,
    B_TXEN_HIGH,
    B_PASS_LOW
  } mloc_b_func_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mloc_bus_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] len;
    logic err;
  } mloc_rsp_t;

endpackage

// File: src/mloc_conn_msg.sv
/*
  Serialiser for the connect message: the fixed word followed by the
  remote source address as four upper-case hex characters.
  Assumes the sink accepts a byte when ready_i is high beside valid_o.
*/
`timescale 1ns/1ps
`default_nettype none

module mloc_conn_msg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Request
  input wire logic start_i,
  input wire logic [15:0] addr_i,
  output logic busy_o,
  // Byte stream to the host
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o
);

  typedef enum logic {MS_IDLE, MS_SEND} mloc_msg_state_t;

  mloc_msg_state_t state_q;
  logic [3:0] idx_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;

  function automatic logic [7:0] char_at(input logic [3:0] i, input logic [15:0] a);
    logic [3:0] h;
    h = 4'h0;
    if (i < mloc_pkg::MSG_WORD_LEN) begin
      return mloc_pkg::MSG_WORD[8*(6-i) +: 8];
    end
    h = a[4*(10-i) +: 4];
    // Hex digits, most significant first, right after the word
    if (h < 4'ha) begin
      return mloc_pkg::ASCII_ZERO + {4'h0, h};
    end
    return mloc_pkg::ASCII_ALPHA_OFS + {4'h0, h};
  endfunction

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= MS_IDLE;
      idx_q <= 4'h0;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else begin
      case (state_q)
        MS_IDLE: begin
          if (start_i) begin
            state_q <= MS_SEND;
            idx_q <= 4'h0;
            addr_q <= addr_i;
            data_q <= char_at(4'h0, addr_i);
          end
        end
        MS_SEND: begin
          if (ready_i) begin
            if (idx_q == mloc_pkg::MSG_LAST_IDX) begin
              state_q <= MS_IDLE;
            end else begin
              idx_q <= idx_q + 4'h1;
              data_q <= char_at(idx_q + 4'h1, addr_q);
            end
          end
        end
        default: begin
          state_q <= MS_IDLE;
        end
      endcase
    end
  end

  assign valid_o = (state_q == MS_SEND);
  assign busy_o = (state_q == MS_SEND);
  assign data_o = data_q;

endmodule

`default_nettype wire

// File: src/mloc_option_cmds.sv
/*
  Option command handling of a stand-alone radio modem: connect message
  switch, explicit exit from text command mode, watchdog on the third
  output line and function select of the second output line.
  Assumes all inputs come from logic on the same 25 MHz clock; the command
  port is a plain strobe bus with read data one cycle after the strobe.
*/
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module mloc_option_cmds #(
  parameter int CLK_PER_SEC = mloc_pkg::CYCLES_PER_SEC,
  parameter logic OUT_C_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Command port
  input wire mloc_pkg::mloc_bus_req_t bus_i,
  output mloc_pkg::mloc_rsp_t rsp_o,
  // Connection events from the link logic
  input wire logic is_base_i,
  input wire logic conn_est_i,
  input wire logic [15:0] remote_addr_i,
  // Connect message to the host
  input wire logic msg_ready_i,
  output logic msg_valid_o,
  output logic [7:0] msg_data_o,
  // Text command mode
  input wire logic cmd_mode_enter_i,
  input wire logic cmd_mode_expire_i,
  output logic cmd_mode_o,
  output logic leave_cmd_mode_o,
  // Third output line and remote status updates
  input wire logic in_c_upd_i,
  input wire logic in_c_level_i,
  output logic out_line_c_o,
  // Second output line
  input wire logic rx_ready_i,
  input wire logic tx_active_i,
  output logic out_line_b_o
);

  localparam int DIV_W = $clog2(CLK_PER_SEC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_SEC - 1);

  logic connect_report_q;
  logic [15:0] out_c_timeout_q;
  mloc_pkg::mloc_b_func_t b_func_q;
  logic cmd_mode_q;
  logic leave_q;
  mloc_pkg::mloc_rsp_t rsp_q;
  logic [DIV_W-1:0] div_q;
  logic [15:0] sec_q;
  logic out_c_q;
  logic out_b_q;
  logic msg_busy;
  logic wr_report, wr_timeout, wr_func, wr_leave;
  logic report_ok, func_ok;
  logic sec_tick, expired;

  function automatic logic known_cmd(input logic [7:0] a);
    return (a == mloc_pkg::CMD_CONNECT_REPORT) || (a == mloc_pkg::CMD_OUT_C_TIMEOUT) ||
           (a == mloc_pkg::CMD_OUT_B_FUNC) || (a == mloc_pkg::CMD_LEAVE_MODE);
  endfunction

  // Command decode
  assign wr_report = bus_i.wr && (bus_i.addr == mloc_pkg::CMD_CONNECT_REPORT);
  assign wr_timeout = bus_i.wr && (bus_i.addr == mloc_pkg::CMD_OUT_C_TIMEOUT);
  assign wr_func = bus_i.wr && (bus_i.addr == mloc_pkg::CMD_OUT_B_FUNC);
  assign wr_leave = bus_i.wr && (bus_i.addr == mloc_pkg::CMD_LEAVE_MODE);
  assign report_ok = (bus_i.wdata <= mloc_pkg::CONNECT_REPORT_MAX);
  assign func_ok = (bus_i.wdata <= mloc_pkg::OUT_B_FUNC_MAX);

  // Out of range values are dropped so the setting keeps a legal value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      connect_report_q <= mloc_pkg::CONNECT_REPORT_RST;
    end else if (wr_report && report_ok) begin
      connect_report_q <= bus_i.wdata[0];
    end
  end

  // Full 16-bit range is legal
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_c_timeout_q <= mloc_pkg::OUT_C_TIMEOUT_RST;
    end else if (wr_timeout) begin
      out_c_timeout_q <= bus_i.wdata;
    end
  end

  // CTS after reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      b_func_q <= mloc_pkg::B_CTS;
    end else if (wr_func && func_ok) begin
      b_func_q <= mloc_pkg::mloc_b_func_t'(bus_i.wdata[2:0]);
    end
  end

  // Read answers and write errors, one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= '0;
      if (bus_i.rd) begin
        case (bus_i.addr)
          mloc_pkg::CMD_CONNECT_REPORT: begin
            rsp_q.data <= {15'h0000, connect_report_q};
            rsp_q.len <= mloc_pkg::LEN_ONE;
          end
          mloc_pkg::CMD_OUT_C_TIMEOUT: begin
            rsp_q.data <= out_c_timeout_q;
            rsp_q.len <= mloc_pkg::LEN_TWO;
          end
          mloc_pkg::CMD_OUT_B_FUNC: begin
            rsp_q.data <= {13'h0000, b_func_q};
            rsp_q.len <= mloc_pkg::LEN_ONE;
          end
          default: begin
            rsp_q.err <= 1'b1;
          end
        endcase
      end else if (bus_i.wr) begin
        rsp_q.err <= !known_cmd(bus_i.addr) || (wr_report && !report_ok) ||
                     (wr_func && !func_ok);
      end
    end
  end

  assign rsp_o = rsp_q;

  // Leaving wins over a simultaneous entry, no inactivity wait
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_mode_q <= 1'b0;
      leave_q <= 1'b0;
    end else begin
      leave_q <= wr_leave && cmd_mode_q;
      if (wr_leave || cmd_mode_expire_i) begin
        cmd_mode_q <= 1'b0;
      end else if (cmd_mode_enter_i) begin
        cmd_mode_q <= 1'b1;
      end
    end
  end

  assign cmd_mode_o = cmd_mode_q;
  assign leave_cmd_mode_o = leave_q;

  // Second prescaler, restarted by each update so the window is exact
  assign sec_tick = (div_q == DIV_LAST);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else if (in_c_upd_i || sec_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sec_q <= 16'h0000;
    end else if (in_c_upd_i) begin
      sec_q <= 16'h0000;
    end else if (sec_tick && (sec_q != 16'hffff)) begin
      sec_q <= sec_q + 16'h0001;
    end
  end

  // A zero timeout disables the watchdog
  assign expired = (out_c_timeout_q != 16'h0000) && (sec_q >= out_c_timeout_q);

  // A fresh update wins over expiry in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_c_q <= OUT_C_DEFAULT;
    end else if (in_c_upd_i) begin
      out_c_q <= in_c_level_i;
    end else if (expired) begin
      out_c_q <= OUT_C_DEFAULT;
    end
  end

  assign out_line_c_o = out_c_q;

  // CTS is active low: low while the receive side can take data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_b_q <= 1'b0;
    end else begin
      case (b_func_q)
        mloc_pkg::B_CTS: out_b_q <= !rx_ready_i;
        mloc_pkg::B_TXEN_LOW: out_b_q <= !tx_active_i;
        mloc_pkg::B_TXEN_HIGH: out_b_q <= tx_active_i;
        mloc_pkg::B_PASS_HIGH: out_b_q <= 1'b1;
        mloc_pkg::B_PASS_LOW: out_b_q <= 1'b0;
        default: out_b_q <= !rx_ready_i;
      endcase
    end
  end

  assign out_line_b_o = out_b_q;

  // A connection while a message is still going out is not reported
  mloc_conn_msg u_msg (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(conn_est_i && connect_report_q && is_base_i),
    .addr_i(remote_addr_i),
    .busy_o(msg_busy),
    .ready_i(msg_ready_i),
    .valid_o(msg_valid_o),
    .data_o(msg_data_o)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  report_msg_start_a: assert property (
    conn_est_i && connect_report_q && is_base_i && !msg_busy
    |=> msg_valid_o && (msg_data_o == mloc_pkg::MSG_WORD[55:48]))
    else $error("connect message did not start");

  report_off_quiet_a: assert property (
    !msg_busy && !(conn_est_i && connect_report_q && is_base_i) |=> !msg_valid_o)
    else $error("message sent without an enabled connection");

  report_range_a: assert property (
    bus_i.wr && (bus_i.addr == mloc_pkg::CMD_CONNECT_REPORT) && (bus_i.wdata > 16'h0001)
    |=> $stable(connect_report_q) && rsp_o.err)
    else $error("out of range report value accepted");

  report_read_a: assert property (
    bus_i.rd && (bus_i.addr == mloc_pkg::CMD_CONNECT_REPORT)
    |=> (rsp_o.len == mloc_pkg::LEN_ONE) && (rsp_o.data == {15'h0000, connect_report_q}))
    else $error("report read answer wrong");

  leave_mode_a: assert property (
    bus_i.wr && (bus_i.addr == mloc_pkg::CMD_LEAVE_MODE) && cmd_mode_o
    |=> !cmd_mode_o && leave_cmd_mode_o ##1 !leave_cmd_mode_o)
    else $error("command mode not left at once");

  out_c_expire_a: assert property (
    expired && !in_c_upd_i |=> out_line_c_o == OUT_C_DEFAULT)
    else $error("third output did not return to default");

  out_c_follow_a: assert property (
    in_c_upd_i |=> (out_line_c_o == $past(in_c_level_i)) && (sec_q == 16'h0000))
    else $error("third output did not follow update");

  timeout_read_a: assert property (
    bus_i.rd && (bus_i.addr == mloc_pkg::CMD_OUT_C_TIMEOUT)
    |=> (rsp_o.len == mloc_pkg::LEN_TWO) && (rsp_o.data == $past(out_c_timeout_q)))
    else $error("timeout read answer wrong");

  out_b_cts_a: assert property (
    (b_func_q == mloc_pkg::B_CTS) |=> out_line_b_o == !$past(rx_ready_i))
    else $error("second output not acting as CTS");

  out_b_txen_a: assert property (
    (b_func_q == mloc_pkg::B_TXEN_HIGH) |=> out_line_b_o == $past(tx_active_i))
    else $error("second output not a high TX enable");

  func_range_a: assert property (
    bus_i.wr && (bus_i.addr == mloc_pkg::CMD_OUT_B_FUNC) && (bus_i.wdata > 16'h0004)
    |=> $stable(b_func_q) && rsp_o.err)
    else $error("out of range function accepted");

  func_read_a: assert property (
    bus_i.rd && (bus_i.addr == mloc_pkg::CMD_OUT_B_FUNC)
    |=> (rsp_o.len == mloc_pkg::LEN_ONE) && (rsp_o.data == {13'h0000, $past(b_func_q)}))
    else $error("function read answer wrong");

  txen_low_a: assert property (
    (b_func_q == mloc_pkg::B_TXEN_LOW) |=> out_line_b_o == !$past(tx_active_i))
    else $error("second output not a low TX enable");

  out_c_hold_a: assert property (
    (out_c_timeout_q == 16'h0000) && !in_c_upd_i |=> $stable(out_line_c_o))
    else $error("third output changed with the watchdog off");

  // Last byte taken and the stream goes quiet
  msg_sent_c: cover property (
    msg_valid_o && msg_ready_i ##1 !msg_valid_o);
  leave_c: cover property (cmd_mode_o ##1 leave_cmd_mode_o);
  expire_c: cover property (out_line_c_o != OUT_C_DEFAULT ##1 expired ##1
    out_line_c_o == OUT_C_DEFAULT);
  func_change_c: cover property (b_func_q == mloc_pkg::B_CTS ##1
    b_func_q == mloc_pkg::B_TXEN_LOW);

endmodule

`default_nettype wire

// File: sim/mloc_host_model.sv
/*
  Host-side model of the connect message sink: collects the bytes that
  the block sends, and can stall by taking a byte every other cycle.
  Assumes the same clock and reset as the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module mloc_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control from the bench
  input wire logic stall_i,
  input wire logic clear_i,
  // Byte stream from the block
  input wire logic msg_valid_i,
  input wire logic [7:0] msg_data_i,
  output logic msg_ready_o
);
  logic [7:0] rx_bytes [0:15];
  int count;
  logic toggle_q;

  // A slow host makes the block hold each byte for an extra cycle
  assign msg_ready_o = stall_i ? toggle_q : 1'b1;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      toggle_q <= 1'b0;
      count <= 0;
    end else begin
      toggle_q <= ~toggle_q;
      if (clear_i) begin
        count <= 0;
      end else if (msg_valid_i && msg_ready_o) begin
        rx_bytes[count[3:0]] <= msg_data_i;
        count <= count + 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: sim/mloc_option_cmds_tb.sv
/*
  Self-checking bench for the option command block: command table in
  rows, then connect message, command mode, watchdog and second output.
  Assumes the host model file is compiled first; short second of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module mloc_option_cmds_tb;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] d;
    logic [1:0] len;
    logic err;
  } mloc_tb_row_t;

  localparam mloc_tb_row_t ROWS [14] = '{
    '{1'b0, 8'h38, 16'h0000, 16'h0000, 2'h1, 1'b0},
    '{1'b0, 8'h2e, 16'h0000, 16'h0003, 2'h2, 1'b0},
    '{1'b0, 8'h1f, 16'h0000, 16'h0000, 2'h1, 1'b0},
    '{1'b1, 8'h38, 16'h0002, 16'h0000, 2'h0, 1'b1},
    '{1'b0, 8'h38, 16'h0000, 16'h0000, 2'h1, 1'b0},
    '{1'b1, 8'h38, 16'h0001, 16'h0000, 2'h0, 1'b0},
    '{1'b0, 8'h38, 16'h0000, 16'h0001, 2'h1, 1'b0},
    '{1'b1, 8'h1f, 16'h0005, 16'h0000, 2'h0, 1'b1},
    '{1'b0, 8'h1f, 16'h0000, 16'h0000, 2'h1, 1'b0},
    '{1'b1, 8'h2e, 16'hffff, 16'h0000, 2'h0, 1'b0},
    '{1'b0, 8'h2e, 16'h0000, 16'hffff, 2'h2, 1'b0},
    '{1'b0, 8'h09, 16'h0000, 16'h0000, 2'h0, 1'b1},
    '{1'b0, 8'h55, 16'h0000, 16'h0000, 2'h0, 1'b1},
    '{1'b1, 8'h55, 16'h0001, 16'h0000, 2'h0, 1'b1}
  };

  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  mloc_pkg::mloc_bus_req_t bus = '0;
  mloc_pkg::mloc_rsp_t rsp;
  logic is_base = 1'b1;
  logic conn_est = 1'b0;
  logic [15:0] remote_addr = 16'h0000;
  logic msg_ready, msg_valid, stall = 1'b0, clear = 1'b0;
  logic [7:0] msg_data;
  logic mode_enter = 1'b0, mode_expire = 1'b0, cmd_mode, leave;
  logic upd = 1'b0, upd_level = 1'b0, out_c;
  logic rx_ready = 1'b1, tx_active = 1'b0, out_b, exp_b;
  int miscompares = 0;
  int check_count = 0;

  always #20 clk_i = ~clk_i;

  mloc_option_cmds #(.CLK_PER_SEC(4), .OUT_C_DEFAULT(1'b1)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rsp_o(rsp),
    .is_base_i(is_base), .conn_est_i(conn_est), .remote_addr_i(remote_addr),
    .msg_ready_i(msg_ready), .msg_valid_o(msg_valid), .msg_data_o(msg_data),
    .cmd_mode_enter_i(mode_enter), .cmd_mode_expire_i(mode_expire),
    .cmd_mode_o(cmd_mode), .leave_cmd_mode_o(leave),
    .in_c_upd_i(upd), .in_c_level_i(upd_level), .out_line_c_o(out_c),
    .rx_ready_i(rx_ready), .tx_active_i(tx_active), .out_line_b_o(out_b)
  );

  mloc_host_model host (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall), .clear_i(clear),
    .msg_valid_i(msg_valid), .msg_data_i(msg_data), .msg_ready_o(msg_ready)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One strobe, then the registered answer in the following cycle
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                        input logic [15:0] d, input logic [1:0] len, input logic err);
    @(posedge clk_i);
    bus.wr <= wr;
    bus.rd <= !wr;
    bus.addr <= addr;
    bus.wdata <= wdata;
    @(posedge clk_i);
    bus <= '0;
    #1;
    check(rsp.data, d);
    check({14'h0, rsp.len}, {14'h0, len});
    check({15'h0, rsp.err}, {15'h0, err});
  endtask

  task automatic connect(input logic [15:0] a, input logic [87:0] exp, input int n);
    @(posedge clk_i);
    clear <= 1'b1;
    @(posedge clk_i);
    clear <= 1'b0;
    conn_est <= 1'b1;
    remote_addr <= a;
    @(posedge clk_i);
    conn_est <= 1'b0;
    for (int i = 0; i < 60 && host.count < 11; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    #1;
    check(16'(host.count), 16'(n));
    for (int i = 0; i < n; i++) check({8'h0, host.rx_bytes[i]}, {8'h0, exp[87-8*i -: 8]});
  endtask

  // Update arrives, the line follows it in the next cycle
  task automatic update(input logic level);
    @(posedge clk_i);
    upd <= 1'b1;
    upd_level <= level;
    @(posedge clk_i);
    upd <= 1'b0;
    #1;
    check({15'h0, out_c}, {15'h0, level});
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check({15'h0, out_b}, {15'h0, !rx_ready});
    check({15'h0, out_c}, 16'h0001);
    for (int r = 0; r < 14; r++) begin
      access(ROWS[r].wr, ROWS[r].addr, ROWS[r].wdata, ROWS[r].d, ROWS[r].len, ROWS[r].err);
    end
    // Back-to-back write then read
    @(posedge clk_i);
    bus.wr <= 1'b1;
    bus.addr <= mloc_pkg::CMD_OUT_B_FUNC;
    bus.wdata <= 16'h0003;
    @(posedge clk_i);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus <= '0;
    #1;
    check(rsp.data, 16'h0003);
    // Reporting on: base reports to stalled and prompt hosts; remote, then reporting off, stay quiet
    stall <= 1'b1;
    connect(16'h1a2f, "CONNECT1A2F", 11);
    stall <= 1'b0;
    connect(16'hb0e9, "CONNECTB0E9", 11);
    is_base <= 1'b0;
    connect(16'h1234, "CONNECT1234", 0);
    is_base <= 1'b1;
    access(1'b1, 8'h38, 16'h0000, 16'h0000, 2'h0, 1'b0);
    connect(16'h1234, "CONNECT1234", 0);
    // Command mode: explicit leave, then timeout expiry
    @(posedge clk_i);
    mode_enter <= 1'b1;
    @(posedge clk_i);
    mode_enter <= 1'b0;
    #1;
    check({15'h0, cmd_mode}, 16'h0001);
    access(1'b1, 8'h09, 16'h0000, 16'h0000, 2'h0, 1'b0);
    check({14'h0, cmd_mode, leave}, 16'h0001);
    @(posedge clk_i);
    #1;
    check({15'h0, leave}, 16'h0000);
    mode_enter <= 1'b1;
    @(posedge clk_i);
    mode_enter <= 1'b0;
    mode_expire <= 1'b1;
    @(posedge clk_i);
    mode_expire <= 1'b0;
    @(posedge clk_i);
    #1;
    check({14'h0, cmd_mode, leave}, 16'h0000);
    // Watchdog: one second, then two seconds kept alive, then disabled
    access(1'b1, 8'h2e, 16'h0001, 16'h0000, 2'h0, 1'b0);
    update(1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    check({15'h0, out_c}, 16'h0000);
    repeat (5) @(posedge clk_i);
    #1;
    check({15'h0, out_c}, 16'h0001);
    access(1'b1, 8'h2e, 16'h0002, 16'h0000, 2'h0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      update(1'b0);
      repeat (5) @(posedge clk_i);
      #1;
      check({15'h0, out_c}, 16'h0000);
    end
    repeat (14) @(posedge clk_i);
    #1;
    check({15'h0, out_c}, 16'h0001);
    access(1'b1, 8'h2e, 16'h0000, 16'h0000, 2'h0, 1'b0);
    update(1'b0);
    repeat (40) @(posedge clk_i);
    #1;
    check({15'h0, out_c}, 16'h0000);
    // Every second-output function against every input pair
    for (int f = 0; f < 5; f++) begin
      access(1'b1, 8'h1f, 16'(f), 16'h0000, 2'h0, 1'b0);
      for (int c = 0; c < 4; c++) begin
        @(posedge clk_i);
        rx_ready <= c[0];
        tx_active <= c[1];
        @(posedge clk_i);
        #1;
        case (f)
          0: exp_b = !c[0];
          1: exp_b = !c[1];
          2: exp_b = 1'b1;
          3: exp_b = c[1];
          default: exp_b = 1'b0;
        endcase
        check({15'h0, out_b}, {15'h0, exp_b});
      end
    end
    // Reset in mid-run must bring every setting back to its default
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      access(ROWS[r].wr, ROWS[r].addr, ROWS[r].wdata, ROWS[r].d, ROWS[r].len, ROWS[r].err);
    end
    results();
  end
endmodule

`default_nettype wire
